// [src/ssf_pkg.sv]
// shared constants of the serial frame port
package ssf_pkg;
    localparam int FRAME_W        = 16;
    localparam int FRAME_LOG2     = 4;
    localparam int PAYLOAD_W      = FRAME_W - 1;
    localparam int SYNC_STAGES    = 2;
    localparam int DEB_SAMPLES    = 3;
    localparam int EDGE_CNT_W     = 8;
    localparam int RX_FIFO_DEPTH  = 8;
    localparam bit PARITY_ODD_DEF = 1'b1;
    localparam int PIN_COUNT      = 3;
    localparam int PIN_SEL        = 2;
    localparam int PIN_CLK        = 1;
    localparam int PIN_DIN        = 0;
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = 3'h7;
    localparam int CLK_SYS_HZ     = 100_000_000;
    localparam int LINK_MAX_BAUD  = 2_000_000;
    localparam int LINK_MIN_HALF_CYC = CLK_SYS_HZ / LINK_MAX_BAUD / 2;
    typedef logic [FRAME_W-1:0] ssf_word_t;
endpackage

// [src/ssf_fifo.sv]
// buffer for received words, registered read data
`timescale 1ns/100ps
module ssf_fifo #(
    parameter int WIDTH = ssf_pkg::FRAME_W,
    parameter int DEPTH = ssf_pkg::RX_FIFO_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;

    wire push      = in_valid & in_ready;
    wire out_free  = ~out_valid | out_ready;
    wire pop       = out_free & (count != '0);

    // the output register holds one of the DEPTH words, so it counts as well
    wire [AW:0] held = count + {{AW{1'b0}}, out_valid};

    assign in_ready = (held < DEPTH_CNT);

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr   <= (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
                out_data <= mem[rd_ptr];
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
            if (out_free) begin
                out_valid <= (count != '0);
            end
        end
    end
endmodule // ssf_fifo

// [src/ssf_frame_port.sv]
// serial slave frame port: filtered pins, shift register, frame checks
// Contract
// - the port is a full-duplex slave only and never drives clock or select.
// - frames are 16 bits, the reply carries a parity bit in its LSB, parity check is optional.
// - bits shift straight through the register so chains of any depth work.
// - while deselected, clock and data are ignored and the output is released.
// - on select the output register is loaded with the reply to the prior access.
// - each rising clock edge while selected puts the next bit out, MSB first.
// - at deselect, rising and falling counts must match and be a multiple of 16.
// - after the count check the received word must be valid, else an error.
// - only an error-free word is handed to the internal logic.
// - data, clock and select each pass their own glitch filter.
// - a new level is accepted only after three equal samples in a row.
`timescale 1ns/100ps
module ssf_frame_port #(
    parameter int CNT_W      = ssf_pkg::EDGE_CNT_W,
    parameter int FIFO_DEPTH = ssf_pkg::RX_FIFO_DEPTH,
    parameter bit PARITY_ODD = ssf_pkg::PARITY_ODD_DEF
) (
    input  wire logic                            clk_sys,
    input  wire logic                            srst,
    input  wire logic                            select_low,
    input  wire logic                            serial_clock,
    input  wire logic                            serial_in,
    output logic                                 serial_out,
    output logic                                 serial_out_oe,
    input  wire logic                            parity_check_en,
    input  wire logic [ssf_pkg::PAYLOAD_W-1:0]   reply_data,
    output logic                                 reply_taken,
    output logic                                 spi_error,
    output logic [ssf_pkg::FRAME_W-1:0]          rx_data,
    output logic                                 rx_valid,
    input  wire logic                            rx_ready
);
    localparam int NP  = ssf_pkg::PIN_COUNT;
    localparam int DEB = ssf_pkg::DEB_SAMPLES;

    logic [NP-1:0]         raw_pins;
    logic [NP-1:0]         filt;
    logic                  sel_q;
    logic                  clk_q;
    ssf_pkg::ssf_word_t    shreg;
    logic [CNT_W-1:0]      rise_cnt;
    logic [CNT_W-1:0]      fall_cnt;
    logic                  fifo_in_ready;
    logic                  edges_seen;

    // only pins are sampled; nothing here drives clock or select
    assign raw_pins = {select_low, serial_clock, serial_in};

    // per pin: two-stage synchroniser, then three-sample debounce
    for (genvar g = 0; g < NP; g++) begin : g_deb
        logic           s1;
        logic           s2;
        logic [DEB-1:0] hist;
        logic           f;
        always_ff @(posedge clk_sys) begin
            if (srst) begin
                s1 <= ssf_pkg::PIN_IDLE[g];
                s2 <= ssf_pkg::PIN_IDLE[g];
            end else begin
                s1 <= raw_pins[g];
                s2 <= s1;
            end
        end
        // filter restarts at the pulled-up idle level of the pin
        always_ff @(posedge clk_sys) begin
            if (srst) begin
                hist <= {DEB{ssf_pkg::PIN_IDLE[g]}};
                f    <= ssf_pkg::PIN_IDLE[g];
            end else begin
                hist <= {hist[DEB-2:0], s2};
                // a change shorter than the window never reaches f
                if (hist == '0) begin
                    f <= 1'b0;
                end else if (hist == '1) begin
                    f <= 1'b1;
                end
            end
        end
        assign filt[g] = f;
    end

    wire sel_f    = filt[ssf_pkg::PIN_SEL];
    wire clk_f    = filt[ssf_pkg::PIN_CLK];
    wire din_f    = filt[ssf_pkg::PIN_DIN];

    wire frame_start = ~sel_f & sel_q;
    wire frame_stop  = sel_f & ~sel_q;
    // edges count only while already selected; select edges gate them
    wire selected    = ~sel_f & ~sel_q;
    wire clk_rise    = selected & clk_f & ~clk_q;
    wire clk_fall    = selected & ~clk_f & clk_q;

    wire reply_par   = (^reply_data) ^ PARITY_ODD;
    wire [ssf_pkg::FRAME_W-1:0] reply_word = {reply_data, reply_par};

    wire [CNT_W-1:0] next_rise = rise_cnt + 1'b1;
    wire [CNT_W-1:0] next_fall = fall_cnt + 1'b1;
    wire             out_bit   = shreg[ssf_pkg::FRAME_W-1];
    // counts wrap on long chains, so activity is remembered apart from them
    wire any_edges   = edges_seen;
    wire cnt_ok      = (rise_cnt == fall_cnt)
                     & (rise_cnt[ssf_pkg::FRAME_LOG2-1:0] == '0)
                     & edges_seen;
    wire par_ok      = ((^shreg) == PARITY_ODD);
    wire word_ok     = cnt_ok & (~parity_check_en | par_ok);
    // a full buffer also rejects the word rather than lose it silently
    wire accept      = frame_stop & word_ok & fifo_in_ready;
    wire reject      = frame_stop & any_edges & ~(word_ok & fifo_in_ready);

    // last filtered levels, for edge detection
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sel_q <= 1'b1;
        end else begin
            sel_q <= sel_f;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            clk_q <= 1'b1;
        end else begin
            clk_q <= clk_f;
        end
    end

    // one register shifts out and in, so received bits fall out after 16 clocks
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            shreg <= '0;
        end else if (frame_start) begin
            shreg <= reply_word;
        end else if (clk_fall) begin
            shreg <= {shreg[ssf_pkg::FRAME_W-2:0], din_f};
        end
    end

    // enable follows the filtered select only
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            serial_out_oe <= 1'b0;
        end else if (frame_start) begin
            serial_out_oe <= 1'b1;
        end else if (frame_stop) begin
            serial_out_oe <= 1'b0;
        end
    end

    // output starts low and moves only on a filtered rise
    always_ff @(posedge clk_sys) begin
        if (srst | frame_start) begin
            serial_out <= 1'b0;
        end else if (clk_rise) begin
            serial_out <= out_bit;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst | frame_start) begin
            rise_cnt <= '0;
        end else if (clk_rise) begin
            rise_cnt <= next_rise;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst | frame_start) begin
            fall_cnt <= '0;
        end else if (clk_fall) begin
            fall_cnt <= next_fall;
        end
    end

    // a chain of any depth may end with both counters back at zero
    always_ff @(posedge clk_sys) begin
        if (srst | frame_start) begin
            edges_seen <= 1'b0;
        end else if (clk_rise | clk_fall) begin
            edges_seen <= 1'b1;
        end
    end

    // one pulse per rejected frame; the reason is not kept
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            spi_error <= 1'b0;
        end else begin
            spi_error <= reject;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reply_taken <= 1'b0;
        end else begin
            reply_taken <= frame_start;
        end
    end

    ssf_fifo #(
        .WIDTH (ssf_pkg::FRAME_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .in_data   (shreg),
        .in_valid  (accept),
        .in_ready  (fifo_in_ready),
        .out_data  (rx_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );
endmodule // ssf_frame_port

// [sim/ssf_checker.sv]
// port assertions for the serial frame port
`timescale 1ns/100ps
module ssf_checker (
    input wire logic                        clk_sys,
    input wire logic                        srst,
    input wire logic                        select_low,
    input wire logic                        serial_clock,
    input wire logic                        serial_out,
    input wire logic                        serial_out_oe,
    input wire logic                        reply_taken,
    input wire logic                        spi_error,
    input wire logic [ssf_pkg::FRAME_W-1:0] rx_data,
    input wire logic                        rx_valid,
    input wire logic                        rx_ready
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // eight pin samples cover sync plus filter delay
    a_sel_idle: assert property (select_low[*8] |=> !serial_out_oe)
        else $error("output driven while deselected");
    a_sel_act: assert property ((!select_low)[*8] |=> serial_out_oe)
        else $error("output not driven while selected");
    a_taken_oe: assert property ($rose(serial_out_oe) |-> reply_taken)
        else $error("reply not loaded at select");
    a_out_stable: assert property ((!serial_clock)[*8] ##1
        (serial_out_oe && $past(serial_out_oe)) |-> $stable(serial_out))
        else $error("output moved without clock rise");
    a_out_on_rise: assert property ($changed(serial_out) &&
        serial_out_oe && $past(serial_out_oe) |-> $past(serial_clock, 6))
        else $error("output changed without a clock rise");
    a_err_deselect: assert property (spi_error |-> $fell(serial_out_oe))
        else $error("error outside deselect");
    a_err_no_rx: assert property (spi_error |=> !$rose(rx_valid))
        else $error("rejected word delivered");
    a_rx_after: assert property ($rose(rx_valid) |-> !serial_out_oe)
        else $error("word delivered inside frame");
    a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("word lost before taken");
endmodule // ssf_checker
bind ssf_frame_port ssf_checker i_ssf_checker (.clk_sys, .srst, .select_low, .serial_clock,
    .serial_out, .serial_out_oe, .reply_taken, .spi_error, .rx_data, .rx_valid, .rx_ready);

// [sim/ssf_master_model.sv]
// behavioural link master framing words onto the pins
`timescale 1ns/100ps
module ssf_master_model (
    input  wire logic clk_sys,
    output logic      select_low,
    output logic      serial_clock,
    output logic      serial_in,
    input  wire logic serial_out
);
    initial begin
        select_low = 1'b1;
        serial_clock = 1'b0;
        serial_in = 1'b1;
    end
    // output lags a rise by ~7 cycles, so each bit is read a full period later, 4 cycles after the next rise
    task automatic frame(input logic [31:0] tx, input int nr, input int nf,
                         output ssf_pkg::ssf_word_t rx);
        int n;
        n = (nr > nf) ? nr : nf;
        rx = '0;
        @(posedge clk_sys) select_low <= 1'b0;
        repeat (8) @(posedge clk_sys);
        for (int i = 0; i < n; i++) begin
            serial_clock <= (i < nr);
            serial_in <= tx[n-1-i];
            repeat (4) @(posedge clk_sys);
            rx = {rx[14:0], serial_out};
            if (i < nf) serial_clock <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
        repeat (4) @(posedge clk_sys);
        rx = {rx[14:0], serial_out};
        select_low <= 1'b1;
        serial_in <= 1'b1;
        repeat (12) @(posedge clk_sys);
        serial_clock <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule // ssf_master_model

// [sim/testbench.sv]
// self-checking bench for the serial frame port
`timescale 1ns/100ps
module testbench;
    logic               clk_sys = 1'b0;
    logic               srst = 1'b1;
    logic               parity_check_en = 1'b1;
    logic               rx_ready = 1'b1;
    logic [14:0]        reply_data = 15'h0000;
    logic               select_low, serial_clock, serial_in, serial_out, serial_out_oe;
    logic               reply_taken, spi_error, rx_valid;
    ssf_pkg::ssf_word_t rx_data, got;
    ssf_pkg::ssf_word_t rxq[$];
    int                 failures = 0;
    int                 checks_done = 0;
    int                 errs = 0;
    int                 takes = 0;
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
        if (spi_error === 1'b1) errs++;
        if (reply_taken === 1'b1) takes++;
    end
    ssf_frame_port i_ssf_frame_port (.clk_sys, .srst, .select_low, .serial_clock, .serial_in,
        .serial_out, .serial_out_oe, .parity_check_en, .reply_data, .reply_taken,
        .spi_error, .rx_data, .rx_valid, .rx_ready);
    ssf_master_model i_ssf_master_model (.clk_sys, .select_low, .serial_clock, .serial_in,
        .serial_out);
    function automatic ssf_pkg::ssf_word_t fr(input logic [14:0] d);
        return {d, ~^d};
    endfunction
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            failures++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    task automatic xfer(input logic [31:0] tx, input int nr, input int nf);
        errs = 0;
        takes = 0;
        rxq = {};
        i_ssf_master_model.frame(tx, nr, nf, got);
    endtask
    task automatic t_plain();
        @(posedge clk_sys) reply_data <= 15'h2A5C;
        xfer({16'h0000, fr(15'h1234)}, 16, 16);
        chk(got === fr(15'h2A5C), "reply bits");
        chk(takes == 1 && errs == 0 && serial_out_oe === 1'b0, "select cycle");
        chk(rxq.size() == 1 && rxq[0] === fr(15'h1234), "rx word");
    endtask
    task automatic t_chain();
        xfer({fr(15'h0F0F), fr(15'h7001)}, 32, 32);
        chk(got === fr(15'h0F0F), "chain pass");
        chk(rxq.size() == 1 && rxq[0] === fr(15'h7001), "chain word");
    endtask
    task automatic t_count();
        int nr[4] = '{16, 8, 17, 0};
        int nf[4] = '{15, 8, 17, 0};
        for (int i = 0; i < 4; i++) begin
            xfer(32'h0000_5555, nr[i], nf[i]);
            chk(errs == (nr[i] > 0) && rxq.size() == 0, "edge count");
        end
    endtask
    task automatic t_parity();
        xfer({16'h0000, fr(15'h0321) ^ 16'h0001}, 16, 16);
        chk(errs == 1 && rxq.size() == 0, "parity");
        @(posedge clk_sys) parity_check_en <= 1'b0;
        xfer({16'h0000, fr(15'h0321) ^ 16'h0001}, 16, 16);
        chk(errs == 0 && rxq.size() == 1, "parity off");
        @(posedge clk_sys) parity_check_en <= 1'b1;
    endtask
    // consumer stalls until the buffer refuses, then drains in order
    task automatic t_fifo();
        @(posedge clk_sys) rx_ready <= 1'b0;
        for (int i = 0; i < 9; i++) xfer({16'h0000, fr(15'(i) + 15'h0100)}, 16, 16);
        chk(errs == 1, "full refused");
        @(posedge clk_sys) rx_ready <= 1'b1;
        repeat (12) @(posedge clk_sys);
        chk(rxq.size() == 8, "drain count");
        for (int i = 0; i < 8; i++) chk(rxq[i] === fr(15'(i) + 15'h0100), "order");
    endtask
    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        results();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        t_plain();
        t_chain();
        t_count();
        t_parity();
        t_fifo();
        results();
    end
endmodule // testbench
